// >>> wheel_sensor_cfg.svh
/*
  Offsets, field positions, reset values and timing figures of the wheel sensor simulator.
  Assumes a single 25 MHz pclk; included by its bare name.
*/
`ifndef WHEEL_SENSOR_CFG_SVH
`define WHEEL_SENSOR_CFG_SVH

`define OFS_CTRL        8'h00
`define OFS_FREQ        8'h04
`define OFS_SPEED       8'h08
`define OFS_RADIUS      8'h0c
`define OFS_DUTY        8'h10
`define OFS_TIMING      8'h14
`define OFS_DEFECT      8'h18
`define OFS_STATUS      8'h1c

`define CTRL_ENABLE     0
`define CTRL_MODE       1
`define CTRL_GAP_FLAG   2
`define CTRL_AUX_FLAG   3
`define CTRL_EXT_LEVEL  4
`define CTRL_DIR_INVAL  5
`define CTRL_PAR_ODD    6
`define CTRL_HALT_OFF   7
`define CTRL_DEFECT_ON  8
`define CTRL_GAP_LSB    9
`define CTRL_GAP_MSB    11

`define TIM_TEETH_LSB   0
`define TIM_TEETH_MSB   7
`define TIM_BIT_LSB     8
`define TIM_BIT_MSB     15
`define TIM_HALT_LSB    16
`define TIM_HALT_MSB    31

`define CTRL_RESET      32'h0000_0000
`define FREQ_RESET      32'h0000_0000
`define SPEED_RESET     32'h0000_0000
`define RADIUS_RESET    32'h0000_012c
`define DUTY_RESET      32'h0000_0080
`define TIMING_RESET    32'h0096_3230
`define DEFECT_RESET    32'h0000_0000

`define FREQ_MAX_HZ     32'd5000
`define BIT_LEN_US      8'd50
`define TWO_PI_Q12      32'd25736
`define SPEED_BITS      2
`define DATA_BITS       9

`endif

// >>> wheel_sensor_pkg.sv
/*
  Types shared by the wheel sensor simulator.
  Assumes nothing of its surroundings.
*/
package wheel_sensor_pkg;
  typedef enum logic [1:0] {
    CUR_OFF,
    CUR_LOW,
    CUR_MID,
    CUR_HIGH
  } current_level_t;

  typedef struct packed {
    logic           drive;
    current_level_t level;
    logic           pole;
  } sensor_out_t;

  typedef enum {
    C_START,
    C_DIV,
    C_CLAMP
  } calc_state_t;

  typedef enum {
    F_IDLE,
    F_SPEED,
    F_DATA
  } frame_state_t;
endpackage

// >>> wheel_speed_sensor_sim.sv
/*
  APB controlled wheel speed sensor simulator: tooth timing, protocol frames, standstill pulses.
  Assumes an APB master on pclk and a current driver stage that follows sensor_out.
*/
// Our own choices: the placing of the registers and the APB slave port.
// Overview of operation
// RL1: Drive output only while enable set
// RL2: Frequency mode uses signed frequency value directly
// RL3: Wheel mode derives frequency from speed, radius
// RL4: Duty setting splits tooth period between poles
// RL5: Nine bit protocol word follows each pulse
// RL6: Bit 0 shows air gap limit
// RL7: Bit 1 follows auxiliary error control
// RL8: Bit 2 shows external input level
// RL9: Bit 3 marks direction invalid
// RL10: Bit 4 is sign of command
// RL11: Bits 5 to 7 carry gap code
// RL12: Bit 8 gives even parity by default
// RL13: Parity select chooses even or odd
// RL14: Standstill protocol active while disable is zero
// RL15: Defect pattern suppresses marked teeth when enabled
// RL16: Clamp frequency at maximum, flag error
// RL17: Bit length sets all pulse widths
// RL18: Standstill timer repeats pulse without teeth
// RL19: Mode zero wheel speed, one frequency
// RL20: Frequency equals speed over circumference times teeth
`include "wheel_sensor_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module wheel_speed_sensor_sim #(
  parameter int unsigned CLK_HZ = 25_000_000
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output wheel_sensor_pkg::sensor_out_t  sensor_out,
  output logic                           freq_error
);
  import wheel_sensor_pkg::*;
  localparam logic [31:0] CLK_HZ_W  = 32'(CLK_HZ);
  localparam logic [15:0] CLK_MHZ_W = 16'(CLK_HZ / 1_000_000);
  generate
    if (CLK_HZ < 1_000_000 || CLK_HZ > 1_000_000_000) begin : g_bad_clk
      $error("pclk rate out of range");
    end
  endgenerate
  logic [31:0]  ctrl_reg;
  logic [31:0]  freq_reg;
  logic [31:0]  speed_reg;
  logic [31:0]  radius_reg;
  logic [31:0]  duty_reg;
  logic [31:0]  timing_reg;
  logic [31:0]  defect_reg;
  logic [31:0]  status_val;
  logic [31:0]  rd_next;
  logic         mapped;
  logic         wr_go;

  // APB slave, zero wait state
  assign pready  = 1'b1;
  assign wr_go   = psel & penable & pwrite;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    mapped  = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:   rd_next = ctrl_reg;
      `OFS_FREQ:   rd_next = freq_reg;
      `OFS_SPEED:  rd_next = speed_reg;
      `OFS_RADIUS: rd_next = radius_reg;
      `OFS_DUTY:   rd_next = duty_reg;
      `OFS_TIMING: rd_next = timing_reg;
      `OFS_DEFECT: rd_next = defect_reg;
      `OFS_STATUS: rd_next = status_val;
      default:     mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `CTRL_RESET;
      freq_reg   <= `FREQ_RESET;
      speed_reg  <= `SPEED_RESET;
      radius_reg <= `RADIUS_RESET;
      duty_reg   <= `DUTY_RESET;
      timing_reg <= `TIMING_RESET;
      defect_reg <= `DEFECT_RESET;
    end else if (wr_go) begin
      case (paddr)
        `OFS_CTRL:   ctrl_reg   <= {20'h00000, pwdata[11:0]};
        `OFS_FREQ:   freq_reg   <= pwdata;
        `OFS_SPEED:  speed_reg  <= pwdata;
        `OFS_RADIUS: radius_reg <= {16'h0000, pwdata[15:0]};
        `OFS_DUTY:   duty_reg   <= {24'h000000, pwdata[7:0]};
        `OFS_TIMING: timing_reg <= pwdata;
        `OFS_DEFECT: defect_reg <= pwdata;
        default:     ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  logic        enable;
  logic        freq_mode;
  logic [7:0]  teeth;
  logic [7:0]  bit_us;
  logic [15:0] halt_ms;
  logic [2:0]  gap_distance_code;
  assign enable            = ctrl_reg[`CTRL_ENABLE];
  assign freq_mode         = ctrl_reg[`CTRL_MODE];
  assign gap_distance_code = ctrl_reg[`CTRL_GAP_MSB:`CTRL_GAP_LSB];
  assign teeth             = timing_reg[`TIM_TEETH_MSB:`TIM_TEETH_LSB];
  assign bit_us            = timing_reg[`TIM_BIT_MSB:`TIM_BIT_LSB];
  assign halt_ms           = timing_reg[`TIM_HALT_MSB:`TIM_HALT_LSB];

  // Period calculation by a shared serial divider
  calc_state_t calc_reg;
  logic        stage_reg;
  logic [31:0] num_reg;
  logic [31:0] den_reg;
  logic [31:0] rem_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] freq_abs_reg;
  logic [31:0] period_reg;
  logic        dir_reg;
  logic [32:0] rem_try;
  logic [31:0] speed_abs;
  logic [31:0] cmd_abs;
  logic [47:0] circ_prod;
  logic [31:0] circ_mm;
  logic [31:0] freq_lim;
  logic        over_max;
  assign speed_abs = speed_reg[31] ? 32'(-speed_reg) : speed_reg;
  assign cmd_abs   = freq_reg[31] ? 32'(-freq_reg) : freq_reg;
  assign circ_prod = radius_reg * `TWO_PI_Q12;
  assign circ_mm   = (circ_prod[43:12] == 32'h0) ? 32'h1 : circ_prod[43:12];
  assign rem_try   = {rem_reg, num_reg[31]} - {1'b0, den_reg};
  assign over_max  = num_reg > `FREQ_MAX_HZ; // see RL16
  assign freq_lim  = over_max ? `FREQ_MAX_HZ : num_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_reg     <= C_START;
      stage_reg    <= 1'b0;
      num_reg      <= 32'h0;
      den_reg      <= 32'h1;
      rem_reg      <= 32'h0;
      cnt_reg      <= 6'h0;
      freq_abs_reg <= 32'h0;
      period_reg   <= 32'h0;
      dir_reg      <= 1'b0;
      freq_error   <= 1'b0;
    end else begin
      case (calc_reg)
        C_START: begin
          rem_reg   <= 32'h0;
          cnt_reg   <= 6'h0;
          stage_reg <= 1'b0;
          if (freq_mode) begin // see RL19
            dir_reg  <= freq_reg[31]; // see RL10
            num_reg  <= cmd_abs; // see RL2
            calc_reg <= C_CLAMP;
          end else begin
            dir_reg  <= speed_reg[31]; // see RL10
            num_reg  <= 32'(speed_abs * teeth); // see RL3 see RL20
            den_reg  <= circ_mm;
            calc_reg <= C_DIV;
          end
        end
        C_DIV: begin
          rem_reg <= rem_try[32] ? {rem_reg[30:0], num_reg[31]} : rem_try[31:0];
          num_reg <= {num_reg[30:0], ~rem_try[32]};
          cnt_reg <= cnt_reg + 6'h1;
          if (cnt_reg == 6'd31) begin
            calc_reg <= C_CLAMP;
          end
        end
        C_CLAMP: begin
          if (stage_reg) begin
            period_reg <= num_reg;
            calc_reg   <= C_START;
          end else begin
            freq_abs_reg <= freq_lim;
            freq_error   <= over_max; // see RL16
            num_reg      <= CLK_HZ_W;
            den_reg      <= freq_lim;
            rem_reg      <= 32'h0;
            cnt_reg      <= 6'h0;
            stage_reg    <= 1'b1;
            calc_reg     <= C_DIV;
            if (num_reg == 32'h0) begin
              period_reg <= 32'h0;
              calc_reg   <= C_START;
            end
          end
        end
        default: calc_reg <= C_START;
      endcase
    end
  end
  // Tooth timing and pole split
  logic [31:0] phase_reg;
  logic [7:0]  tooth_idx_reg;
  logic [39:0] high_prod;
  logic        tooth_evt;
  logic        pole;
  logic        defective;
  assign high_prod = period_reg * duty_reg[7:0];
  assign tooth_evt = enable && period_reg != 32'h0 && phase_reg + 32'h1 >= period_reg;
  assign pole      = phase_reg < high_prod[39:8]; // see RL4
  assign defective = ctrl_reg[`CTRL_DEFECT_ON] && defect_reg[tooth_idx_reg[4:0]]; // see RL15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg     <= 32'h0;
      tooth_idx_reg <= 8'h0;
    end else if (!enable || period_reg == 32'h0) begin
      phase_reg <= 32'h0;
    end else if (tooth_evt) begin
      phase_reg     <= 32'h0;
      tooth_idx_reg <= (tooth_idx_reg + 8'h1 >= teeth) ? 8'h0 : tooth_idx_reg + 8'h1;
    end else begin
      phase_reg <= phase_reg + 32'h1;
    end
  end
  // Standstill monitor
  logic [31:0] halt_cnt_reg;
  logic [31:0] halt_cycles;
  logic        halt_evt;
  assign halt_cycles = 32'(halt_ms * CLK_MHZ_W * 32'd1000);
  assign halt_evt    = enable && !ctrl_reg[`CTRL_HALT_OFF] && halt_cnt_reg >= halt_cycles; // see RL14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_reg <= 32'h0;
    end else if (!enable || tooth_evt || halt_evt) begin
      halt_cnt_reg <= 32'h0; // see RL18
    end else begin
      halt_cnt_reg <= halt_cnt_reg + 32'h1;
    end
  end
  // Protocol word
  logic [8:0] word;
  assign word[0]   = ctrl_reg[`CTRL_GAP_FLAG]; // see RL6
  assign word[1]   = ctrl_reg[`CTRL_AUX_FLAG]; // see RL7
  assign word[2]   = ctrl_reg[`CTRL_EXT_LEVEL]; // see RL8
  assign word[3]   = ctrl_reg[`CTRL_DIR_INVAL]; // see RL9
  assign word[4]   = dir_reg; // see RL10
  assign word[7:5] = gap_distance_code; // see RL11
  assign word[8]   = (^word[7:0]) ^ ctrl_reg[`CTRL_PAR_ODD]; // see RL12 see RL13
  // Frame sequencer
  frame_state_t frame_reg;
  logic [15:0]  bit_cnt_reg;
  logic [3:0]   slot_reg;
  logic [8:0]   word_reg;
  logic [15:0]  bit_cycles;
  logic         bit_end;
  assign bit_cycles = (bit_us == 8'h0) ? 16'(`BIT_LEN_US) * CLK_MHZ_W : 16'(bit_us) * CLK_MHZ_W; // see RL17
  assign bit_end    = bit_cnt_reg + 16'h1 >= bit_cycles;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg   <= F_IDLE;
      bit_cnt_reg <= 16'h0;
      slot_reg    <= 4'h0;
      word_reg    <= 9'h0;
    end else if (!enable) begin
      frame_reg <= F_IDLE;
    end else begin
      bit_cnt_reg <= bit_end ? 16'h0 : bit_cnt_reg + 16'h1;
      case (frame_reg)
        F_IDLE: begin
          bit_cnt_reg <= 16'h0;
          slot_reg    <= 4'h0;
          if ((tooth_evt && !defective) || halt_evt) begin
            word_reg  <= word; // see RL5
            frame_reg <= F_SPEED;
          end
        end
        F_SPEED: if (bit_end) begin
          slot_reg <= slot_reg + 4'h1;
          if (slot_reg == 4'(`SPEED_BITS - 1)) begin
            slot_reg  <= 4'h0;
            frame_reg <= F_DATA;
          end
        end
        F_DATA: if (bit_end) begin
          slot_reg <= slot_reg + 4'h1;
          if (slot_reg == 4'(`DATA_BITS - 1)) begin
            frame_reg <= F_IDLE;
          end
        end
        default: frame_reg <= F_IDLE;
      endcase
    end
  end
  current_level_t level_next;
  always_comb begin
    case (frame_reg)
      F_SPEED: level_next = CUR_HIGH;
      F_DATA:  level_next = word_reg[slot_reg] ? CUR_MID : CUR_LOW;
      default: level_next = CUR_LOW;
    endcase
    if (!enable) begin
      level_next = CUR_OFF; // see RL1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_out <= '{drive: 1'b0, level: CUR_OFF, pole: 1'b0};
    end else begin
      sensor_out <= '{drive: enable, level: level_next, pole: enable & pole}; // see RL1
    end
  end
  assign status_val = {freq_abs_reg[15:0], 13'h0000, frame_reg != F_IDLE, dir_reg, freq_error};
endmodule

`default_nettype wire

// >>> wheel_sensor_chk.sv
/*
  Concurrent checks on the wheel sensor simulator ports.
  Assumes one pclk domain with presetn; bound to the top module below.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wheel_sensor_cfg.svh"
module wheel_sensor_chk (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [7:0]                    paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire wheel_sensor_pkg::sensor_out_t sensor_out,
  input wire logic                          freq_error
);
  import wheel_sensor_pkg::*;
  logic [31:0] ctrl_reg;
  logic [7:0]  bit_us_reg;
  logic [15:0] hi_cnt_reg;
  logic        wr;
  logic        wr_freq;
  int unsigned bit_cyc;
  assign wr = psel && penable && pwrite;
  assign wr_freq = wr && paddr == `OFS_FREQ && ctrl_reg[`CTRL_MODE];
  assign bit_cyc = (bit_us_reg == 8'h00) ? 32'd1250 : bit_us_reg * 25;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= 32'h0;
      bit_us_reg <= 8'h32;
    end else if (wr && paddr == `OFS_CTRL) begin
      ctrl_reg <= pwdata;
    end else if (wr && paddr == `OFS_TIMING) begin
      bit_us_reg <= pwdata[15:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt_reg <= 16'h0;
    else if (sensor_out.drive && sensor_out.level == CUR_HIGH) hi_cnt_reg <= hi_cnt_reg + 16'h1;
    else hi_cnt_reg <= 16'h0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_off_when_disabled: assert property (!sensor_out.drive |-> sensor_out.level == CUR_OFF)
    else $error("level not off while drive low");
  a_drive_follows_enable: assert property (wr && paddr == `OFS_CTRL |=> ##[0:3]
    sensor_out.drive == ctrl_reg[`CTRL_ENABLE]) else $error("drive does not follow enable");
  a_speed_pulse_len: assert property (sensor_out.drive && sensor_out.level != CUR_HIGH
    && hi_cnt_reg != 16'h0 |-> hi_cnt_reg == 2 * bit_cyc) else $error("speed pulse length wrong");
  a_data_slot_levels: assert property (sensor_out.drive && $past(sensor_out.drive) &&
    $past(sensor_out.level) == CUR_HIGH && sensor_out.level != CUR_HIGH |->
    sensor_out.level inside {CUR_LOW, CUR_MID}) else $error("bad level after speed pulse");
  a_clamp_raises: assert property (wr_freq && ($signed(pwdata) > 5000 || $signed(pwdata) < -5000)
    |-> ##[1:200] freq_error) else $error("over frequency not flagged");
  a_clamp_clears: assert property (wr_freq && $signed(pwdata) <= 5000 && $signed(pwdata) >= -5000
    |-> ##[1:200] !freq_error) else $error("frequency error stuck");
  a_status_error: assert property (psel && penable && !pwrite && paddr == `OFS_STATUS
    |-> prdata[0] == $past(freq_error)) else $error("status error bit wrong");
  a_unmapped_err: assert property (psel && penable && paddr > `OFS_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= `OFS_STATUS && paddr[1:0] == 2'b00
    |-> !pslverr && pready) else $error("mapped access refused");
endmodule
bind wheel_speed_sensor_sim wheel_sensor_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sensor_out, .freq_error);
`default_nettype wire

// >>> wheel_vcu_model.sv
/*
  Control unit side: decodes the nine protocol bits from the sensor current.
  Assumes bit slots of BIT_CYC pclk cycles and a speed pulse of two slots.
*/
`timescale 1ns/1ns
`default_nettype none
module wheel_vcu_model #(
  parameter int BIT_CYC = 50
) (
  input wire logic                          pclk,
  input wire wheel_sensor_pkg::sensor_out_t sensor_out,
  output var logic [8:0]                    word,
  output var int                            n_words
);
  import wheel_sensor_pkg::*;
  logic [8:0] w;
  initial begin
    n_words = 0;
    word = 9'h000;
    forever begin
      @(posedge pclk);
      if (sensor_out.drive && sensor_out.level == CUR_HIGH) begin
        repeat (2 * BIT_CYC + BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
          w[i] = (sensor_out.level == CUR_MID);
          repeat (BIT_CYC) @(posedge pclk);
        end
        word = w;
        n_words++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> wheel_speed_sensor_sim_tb.sv
/*
  Self-checking bench for the wheel sensor simulator over APB.
  Assumes zero-wait APB and bit length set to 2 us (50 cycles).
*/
`timescale 1ns/1ns
`default_nettype none
`include "wheel_sensor_cfg.svh"
module wheel_speed_sensor_sim_tb;
  import wheel_sensor_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, freq_error, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  sensor_out_t sensor_out;
  logic [8:0]  word, e, exp_w;
  int          n_words, miscompares, n_tests, k, c0, hi, lo;
  logic [31:0] rst_val [8] = '{`CTRL_RESET, `FREQ_RESET, `SPEED_RESET, `RADIUS_RESET, `DUTY_RESET,
                               `TIMING_RESET, `DEFECT_RESET, 32'h0};
  logic [8:0]  tab [3] = '{{1'b1, 3'd7, 5'b01111}, {1'b0, 3'd5, 5'b10101}, {1'b1, 3'd2, 5'b11010}};
  wheel_speed_sensor_sim uut (.*);
  wheel_vcu_model #(.BIT_CYC(50)) vcu (.pclk, .sensor_out, .word, .n_words);
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_words(input int n);
    c0 = n_words;
    k = 0;
    while (n_words < c0 + n && k < 30000) begin @(posedge pclk); k++; end
    chk("word wait", 32'(k < 30000), 32'h1);
  endtask
  task run_of(input logic v, output int n);
    n = 0;
    while (sensor_out.pole === v && n < 20000) begin @(posedge pclk); n++; end
    chk("pole wait", 32'(n < 20000), 32'h1);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (99000) @(posedge pclk);
    miscompares++;
    stop_test;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    miscompares = 0; n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, rst_val[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");
    apb(1'b1, `OFS_TIMING, 32'h0001_0230);
    apb(1'b1, `OFS_DUTY, 32'h40);
    apb(1'b1, `OFS_FREQ, 32'd5000);
    apb(1'b1, `OFS_CTRL, 32'h83);
    repeat (160) @(posedge pclk);
    run_of(1'b1, k); run_of(1'b0, k); run_of(1'b1, hi); run_of(1'b0, lo);
    chk("pole high", 32'(hi inside {[1249:1251]}), 32'h1);
    chk("tooth period", 32'(hi + lo inside {[4999:5001]}), 32'h1);
    $display("test duty done");
    foreach (tab[i]) begin
      e = tab[i];
      apb(1'b1, `OFS_CTRL, 32'h0);
      repeat (600) @(posedge pclk);
      apb(1'b1, `OFS_FREQ, e[8] ? -32'sd5000 : 32'd5000);
      apb(1'b1, `OFS_CTRL, {20'h0, e[7:5], 1'b0, 1'b1, e[4:0], 2'b11});
      wait_words(1);
      exp_w = {1'b0, e[7:5], e[8], e[3:0]};
      exp_w[8] = ^exp_w[7:0] ^ e[4];
      chk("protocol word", 32'(word), 32'(exp_w));
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("direction", 32'(rd[1]), 32'(e[8]));
    end
    $display("test protocol done");
    apb(1'b1, `OFS_FREQ, 32'd6000);
    repeat (160) @(posedge pclk);
    chk("freq error set", 32'(freq_error), 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("clamped freq", 32'(rd[31:16]), 32'd5000);
    apb(1'b1, `OFS_FREQ, 32'd4000);
    repeat (160) @(posedge pclk);
    chk("freq error clear", 32'(freq_error), 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("direct freq", 32'(rd[31:16]), 32'd4000);
    apb(1'b1, `OFS_SPEED, -32'sd10000);
    apb(1'b1, `OFS_CTRL, 32'h81);
    repeat (160) @(posedge pclk);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("wheel freq", 32'(rd[31:16]), 32'(10000 * 48 / ((300 * 25736) >> 12)));
    chk("wheel direction", 32'(rd[1]), 32'h1);
    apb(1'b1, `OFS_SPEED, 32'd200000);
    repeat (160) @(posedge pclk);
    chk("wheel freq error", 32'(freq_error), 32'h1);
    run_of(1'b1, k); run_of(1'b0, k); run_of(1'b1, hi);
    chk("wheel pole high", 32'(hi inside {[1249:1251]}), 32'h1);
    $display("test clamp and wheel done");
    apb(1'b1, `OFS_DEFECT, 32'hffff_ffff);
    apb(1'b1, `OFS_FREQ, 32'd5000);
    apb(1'b1, `OFS_CTRL, 32'h183);
    repeat (800) @(posedge pclk);
    c0 = n_words;
    repeat (6000) @(posedge pclk);
    chk("defect frames", 32'(n_words), 32'(c0));
    apb(1'b1, `OFS_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk("sensor off", 32'(sensor_out), 32'h0);
    $display("test defect and disable done");
    apb(1'b1, `OFS_FREQ, 32'd0);
    apb(1'b1, `OFS_CTRL, 32'h03);
    wait_words(1);
    chk("standstill pulse", 32'(k < 30000), 32'h1);
    wait_words(1);
    chk("standstill repeat", 32'(k inside {[24990:25010]}), 32'h1);
    $display("test standstill done");
    stop_test;
  end
endmodule
`default_nettype wire
